// >>> aem_pkg.sv
// Shared constants for the alert and power-event mask block
package aem_pkg;

  // ****************************************
  // Bus widths and responses
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_STATE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ALERT_STAT_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_POWER_STAT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_POWER_MASK = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ALERT_MASK_HI = 8'h18;

  // ****************************************
  // Field positions of the upper alert mask byte
  // ****************************************
  localparam int BIT_VENDOR_ALERT = 7;
  localparam int BIT_ALERT_EXTENDED = 6;
  localparam int BIT_EXTENDED_STATUS = 5;
  localparam int BIT_PACKET_START = 4;
  localparam int BIT_SINK_DISCONNECT = 3;
  localparam int BIT_RECEIVE_OVERFLOW = 2;
  localparam int BIT_FAULT_SUMMARY = 1;
  localparam int BIT_ALERT_LOW = 0;

  // ****************************************
  // Field positions of the power event mask, control and state registers
  // ****************************************
  localparam int BIT_BUS_VOLTAGE_LOW = 0;
  localparam int BIT_HARD_RESET_DETECT_EN = 0;
  localparam int BIT_STATE_IRQ = 0;
  localparam int BIT_STATE_PD_CAPABLE = 1;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0] ALERT_MASK_HI_RST = 8'hFF;
  localparam logic [7:0] POWER_MASK_RST = 8'hFF;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;

  // Decode of every mapped register
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
    return (addr == OFS_STATE) || (addr == OFS_CONTROL) || (addr == OFS_ALERT_STAT_HI) ||
           (addr == OFS_POWER_STAT) || (addr == OFS_POWER_MASK) ||
           (addr == OFS_ALERT_MASK_HI);
  endfunction

endpackage

// >>> aem_reg_if.sv
// Register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface aem_reg_if;
  import aem_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  modport slave_end (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input rd_data);
  modport regs_end (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output rd_data);
endinterface

// >>> aem_event_latch.sv
// Sticky event bits, set by hardware, cleared by writing one
`timescale 1ns/1ps
module aem_event_latch import aem_pkg::*; #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Events and clears
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // Sticky state
  output logic [W-1:0] stat
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stat[i] <= 1'b0;
        end else if (set[i]) begin
          stat[i] <= 1'b1;
        end else if (clr[i]) begin
          stat[i] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule // aem_event_latch

// >>> aem_axil_slave.sv
// AXI4-Lite slave front end for the mask register file
`timescale 1ns/1ps
module aem_axil_slave import aem_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register file side
  aem_reg_if.slave_end regs
);
  logic aw_full_q, w_full_q, ar_full_q, wr_go, rd_go;
  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0] wstrb_q;

  assign wr_go = aw_full_q && w_full_q && !bvalid;
  assign rd_go = ar_full_q && !rvalid;
  assign regs.wr_en = wr_go && reg_mapped(awaddr_q);
  assign regs.wr_addr = awaddr_q;
  assign regs.wr_data = wdata_q;
  assign regs.wr_strb = wstrb_q;
  assign regs.rd_en = rd_go;
  assign regs.rd_addr = araddr_q;

  // ****************************************
  // Write channels, taken in either order
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        aw_full_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_full_q <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read channels
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      ar_full_q <= 1'b0;
      araddr_q <= '0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        araddr_q <= araddr;
        ar_full_q <= 1'b1;
        arready <= 1'b0;
      end
      if (rd_go) begin
        ar_full_q <= 1'b0;
        rvalid <= 1'b1;
        rdata <= reg_mapped(araddr_q) ? regs.rd_data : '0;
        rresp <= reg_mapped(araddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // aem_axil_slave

// >>> aem_alert_mask.sv
// Alert and power-event mask registers with sticky events and alert output
//
// How it works
// R1: A cleared mask bit keeps its event off the alert; set bit lets it through.
// R2: Power event mask register at 0x14, one writable bit per power event.
// R3: Power mask returns to defaults on Hard Reset sent, or received when detection enabled.
// R4: Upper alert mask bits 7, 6, 5 are reserved and gate nothing.
// R5: Upper alert mask bits 4 and 3 are reserved; writes to them change nothing.
// R6: Protocol-capable variant gates receive overflow through upper alert mask bit 2.
// R7: Protocol-capable variant gates bus voltage low alarm through a power mask bit.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module aem_alert_mask import aem_pkg::*; #(
  parameter bit PD_CAPABLE = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address and data
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Event pulses, one bit per mask position
  input wire logic [7:0] alert_hi_evt,
  input wire logic [7:0] power_evt,
  // Hard Reset indications
  input wire logic hard_reset_sent,
  input wire logic hard_reset_rcvd,
  // Alert output
  output logic irq
);

  // ****************************************
  // Positions that carry masking behaviour
  // ****************************************
  // Bits 7..3 of the upper alert byte are reserved; bit 2 only on the protocol variant
  localparam logic [7:0] ALERT_LIVE = {5'h00, PD_CAPABLE, 2'h3};
  localparam logic [7:0] POWER_LIVE = {7'h7F, PD_CAPABLE};

  // ****************************************
  // Internal state
  // ****************************************
  aem_reg_if regs ();
  logic [7:0] alert_mask_hi_q;
  logic [7:0] power_mask_q;
  logic [7:0] control_q;
  logic [7:0] alert_stat_q;
  logic [7:0] power_stat_q;
  logic [7:0] alert_clr;
  logic [7:0] power_clr;
  logic [7:0] alert_set;
  logic [7:0] power_set;
  logic low_lane_wr;
  logic alert_mask_wr;
  logic power_mask_wr;
  logic control_wr;
  logic mask_restore;
  logic any_pending;
  logic irq_q;
  logic irq_d;
  logic [DATA_W-1:0] rd_mux;

  // ****************************************
  // Bus slave
  // ****************************************
  aem_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regs(regs.slave_end)
  );

  // ****************************************
  // Write decode
  // ****************************************
  // Registers live in byte lane 0; a write without that lane changes nothing
  assign low_lane_wr = regs.wr_en && regs.wr_strb[0];
  assign alert_mask_wr = low_lane_wr && (regs.wr_addr == OFS_ALERT_MASK_HI);
  assign power_mask_wr = low_lane_wr && (regs.wr_addr == OFS_POWER_MASK);
  assign control_wr = low_lane_wr && (regs.wr_addr == OFS_CONTROL);
  assign alert_clr = (low_lane_wr && (regs.wr_addr == OFS_ALERT_STAT_HI)) ?
                     regs.wr_data[7:0] : 8'h00;
  assign power_clr = (low_lane_wr && (regs.wr_addr == OFS_POWER_STAT)) ?
                     regs.wr_data[7:0] : 8'h00;

  // ****************************************
  // Hard Reset restore
  // ****************************************
  // A received Hard Reset counts only while detection is enabled
  assign mask_restore = hard_reset_sent ||
                        (hard_reset_rcvd && control_q[BIT_HARD_RESET_DETECT_EN]); // R3

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= CONTROL_RST;
    end else if (control_wr) begin
      control_q[BIT_HARD_RESET_DETECT_EN] <= regs.wr_data[BIT_HARD_RESET_DETECT_EN];
    end
  end

  // ****************************************
  // Upper alert mask byte
  // ****************************************
  // Reserved positions hold their reset value and ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_mask_hi_q <= ALERT_MASK_HI_RST;
    end else if (alert_mask_wr) begin
      alert_mask_hi_q <= (alert_mask_hi_q & ~ALERT_LIVE) |
                         (regs.wr_data[7:0] & ALERT_LIVE); // R4 R5 R6
    end
  end

  // ****************************************
  // Power event mask
  // ****************************************
  // Restore takes priority over a write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_mask_q <= POWER_MASK_RST;
    end else if (mask_restore) begin
      power_mask_q <= POWER_MASK_RST; // R3
    end else if (power_mask_wr) begin
      power_mask_q <= (power_mask_q & ~POWER_LIVE) |
                      (regs.wr_data[7:0] & POWER_LIVE); // R2 R7
    end
  end

  // ****************************************
  // Sticky event state
  // ****************************************
  // Reserved positions never latch an event
  assign alert_set = alert_hi_evt & ALERT_LIVE; // R4 R5 R6
  assign power_set = power_evt & POWER_LIVE; // R7

  aem_event_latch #(
    .W(8)
  ) u_alert_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(alert_set),
    .clr(alert_clr),
    .stat(alert_stat_q)
  );

  aem_event_latch #(
    .W(8)
  ) u_power_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(power_set),
    .clr(power_clr),
    .stat(power_stat_q)
  );

  // ****************************************
  // Alert output
  // ****************************************
  assign any_pending = |(alert_stat_q & alert_mask_hi_q & ALERT_LIVE) ||
                       |(power_stat_q & power_mask_q & POWER_LIVE); // R1
  assign irq_d = any_pending;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d; // R1
    end
  end

  assign irq = irq_q;

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rd_mux = '0;
    case (regs.rd_addr)
      OFS_STATE: begin
        rd_mux[BIT_STATE_IRQ] = irq_q;
        rd_mux[BIT_STATE_PD_CAPABLE] = PD_CAPABLE;
      end
      OFS_CONTROL: begin
        rd_mux[7:0] = control_q;
      end
      OFS_ALERT_STAT_HI: begin
        rd_mux[7:0] = alert_stat_q;
      end
      OFS_POWER_STAT: begin
        rd_mux[7:0] = power_stat_q;
      end
      OFS_POWER_MASK: begin
        rd_mux[7:0] = power_mask_q;
      end
      OFS_ALERT_MASK_HI: begin
        rd_mux[7:0] = alert_mask_hi_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  assign regs.rd_data = rd_mux;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_restore_req;
    hard_reset_sent || (hard_reset_rcvd && control_q[BIT_HARD_RESET_DETECT_EN]);
  endsequence

  sequence s_defaults_back;
    power_mask_q == POWER_MASK_RST;
  endsequence

  property p_alert_has_cause;
    @(posedge aclk) disable iff (!aresetn)
      irq_q |-> $past(any_pending);
  endproperty
  a_alert_has_cause: assert property (p_alert_has_cause) // R1
    else $error("alert raised without an unmasked pending event");

  property p_masked_stays_quiet;
    @(posedge aclk) disable iff (!aresetn)
      (!any_pending) [*2] |-> !irq_q;
  endproperty
  a_masked_stays_quiet: assert property (p_masked_stays_quiet) // R1
    else $error("alert high while every pending event is masked");

  property p_unmasked_fires;
    @(posedge aclk) disable iff (!aresetn)
      any_pending |=> irq_q;
  endproperty
  a_unmasked_fires: assert property (p_unmasked_fires) // R1
    else $error("unmasked pending event did not raise the alert");

  property p_power_mask_write;
    @(posedge aclk) disable iff (!aresetn)
      (power_mask_wr && !mask_restore) |=>
        power_mask_q == (($past(power_mask_q) & ~POWER_LIVE) |
                         ($past(regs.wr_data[7:0]) & POWER_LIVE));
  endproperty
  a_power_mask_write: assert property (p_power_mask_write) // R2
    else $error("power mask did not take the written value");

  property p_power_mask_holds;
    @(posedge aclk) disable iff (!aresetn)
      (!power_mask_wr && !mask_restore) |=> $stable(power_mask_q);
  endproperty
  a_power_mask_holds: assert property (p_power_mask_holds) // R2
    else $error("power mask changed without a write or restore");

  property p_restore_defaults;
    @(posedge aclk) disable iff (!aresetn)
      s_restore_req |=> s_defaults_back;
  endproperty
  a_restore_defaults: assert property (p_restore_defaults) // R3
    else $error("power mask not restored after Hard Reset");

  property p_rcvd_ignored_when_off;
    @(posedge aclk) disable iff (!aresetn)
      (hard_reset_rcvd && !control_q[BIT_HARD_RESET_DETECT_EN] && !hard_reset_sent &&
       !power_mask_wr) |=> $stable(power_mask_q);
  endproperty
  a_rcvd_ignored_when_off: assert property (p_rcvd_ignored_when_off) // R3
    else $error("received Hard Reset acted while detection disabled");

  property p_top_reserved_fixed;
    @(posedge aclk) disable iff (!aresetn)
      alert_mask_wr |=> (alert_mask_hi_q[7:5] == ALERT_MASK_HI_RST[7:5]) &&
                        (alert_stat_q[7:5] == 3'h0);
  endproperty
  a_top_reserved_fixed: assert property (p_top_reserved_fixed) // R4
    else $error("reserved upper alert bits 7..5 changed");

  property p_mid_reserved_fixed;
    @(posedge aclk) disable iff (!aresetn)
      alert_mask_wr |=> (alert_mask_hi_q[4:3] == $past(alert_mask_hi_q[4:3])) &&
                        (alert_stat_q[4:3] == 2'h0);
  endproperty
  a_mid_reserved_fixed: assert property (p_mid_reserved_fixed) // R5
    else $error("write changed reserved upper alert bits 4..3");

  generate
    if (PD_CAPABLE) begin : g_pd_checks
      property p_overflow_gate;
        @(posedge aclk) disable iff (!aresetn)
          (alert_stat_q[BIT_RECEIVE_OVERFLOW] && alert_mask_hi_q[BIT_RECEIVE_OVERFLOW])
            |=> irq_q;
      endproperty
      a_overflow_gate: assert property (p_overflow_gate) // R6
        else $error("unmasked receive overflow did not raise the alert");

      property p_vlow_gate;
        @(posedge aclk) disable iff (!aresetn)
          (power_stat_q[BIT_BUS_VOLTAGE_LOW] && power_mask_q[BIT_BUS_VOLTAGE_LOW])
            |=> irq_q;
      endproperty
      a_vlow_gate: assert property (p_vlow_gate) // R7
        else $error("unmasked bus voltage low did not raise the alert");
    end
  endgenerate

  property p_set_beats_clear;
    @(posedge aclk) disable iff (!aresetn)
      (power_set[BIT_BUS_VOLTAGE_LOW] && power_clr[BIT_BUS_VOLTAGE_LOW])
        |=> power_stat_q[BIT_BUS_VOLTAGE_LOW];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // R7
    else $error("event lost when cleared in the same cycle");

endmodule // aem_alert_mask

// >>> aem_mgr_model.sv
// Register-bus master standing in for the external port manager
`timescale 1ns/1ps
module aem_mgr_model import aem_pkg::*; (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  bit hung = 1'b0;

  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // ****************************************
  // Bus cycles; released payload is inverted so stale values never match
  // ****************************************
  // Response readies are raised again by every call and never lowered, so they stay high between transfers
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [1:0] r);
    bit a_ok = 1'b0;
    bit w_ok = 1'b0;
    bit b_ok = 1'b0;
    int n = 0;
    r = 2'h3;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 64) begin
      @(posedge aclk);
      n++;
      if (!a_ok && awready) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        b_ok = 1'b1;
        r = bresp;
      end
    end
    if (!b_ok) hung = 1'b1;
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit a_ok = 1'b0;
    bit r_ok = 1'b0;
    int n = 0;
    d = '1;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 64) begin
      @(posedge aclk);
      n++;
      if (!a_ok && arready) begin
        a_ok = 1'b1;
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        r_ok = 1'b1;
        d = rdata;
        r = rresp;
      end
    end
    if (!r_ok) hung = 1'b1;
  endtask
endmodule // aem_mgr_model

// >>> alert_event_mask_bits_tb.sv
// Self-checking testbench for the alert and power-event mask block
`timescale 1ns/1ps
module alert_event_mask_bits_tb import aem_pkg::*;;
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic [ADDR_W-1:0] araddr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] alert_hi_evt;
  logic [7:0] power_evt;
  logic hard_reset_sent;
  logic hard_reset_rcvd;
  logic irq;
  int err_count = 0;
  int compares = 0;
  int unsigned seed = 42873;
  logic [7:0] m_amask, m_pmask, m_ctrl, m_astat, m_pstat;

  aem_alert_mask i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .alert_hi_evt(alert_hi_evt), .power_evt(power_evt), .hard_reset_sent(hard_reset_sent),
    .hard_reset_rcvd(hard_reset_rcvd), .irq(irq));

  aem_mgr_model i_mgr (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_irq();
    return |((m_astat & m_amask) | (m_pstat & m_pmask));
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic hang_check();
    if (i_mgr.hung) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] r;
    i_mgr.write(a, {xs() & 32'hFFFFFF00} | {24'h0, d}, s, r);
    hang_check();
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    i_mgr.read(a, d, r);
    hang_check();
    chk("rdata", d, {24'h0, ed});
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask

  task automatic check_all();
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq}, {31'h0, exp_irq()});
    rd(OFS_STATE, {6'h0, 1'b1, exp_irq()}, RESP_OKAY);
    rd(OFS_CONTROL, m_ctrl, RESP_OKAY);
    rd(OFS_ALERT_STAT_HI, m_astat, RESP_OKAY);
    rd(OFS_POWER_STAT, m_pstat, RESP_OKAY);
    rd(OFS_POWER_MASK, m_pmask, RESP_OKAY);
    rd(OFS_ALERT_MASK_HI, m_amask, RESP_OKAY);
  endtask

  task automatic hr_pulse(input bit sent);
    @(posedge aclk);
    hard_reset_sent <= sent;
    hard_reset_rcvd <= !sent;
    @(posedge aclk);
    hard_reset_sent <= 1'b0;
    hard_reset_rcvd <= 1'b0;
    if (sent || m_ctrl[0]) m_pmask = 8'hFF;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    {m_amask, m_pmask, m_ctrl, m_astat, m_pstat} = {8'hFF, 8'hFF, 24'h0};
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    logic [31:0] v;
    aresetn = 1'b0;
    {alert_hi_evt, power_evt, hard_reset_sent, hard_reset_rcvd} = '0;
    do_reset();
    check_all();
    rd(8'h10, 8'h00, RESP_SLVERR);
    wr(8'h1C, 8'h00, 4'hF, RESP_SLVERR);
    wr(OFS_STATE, 8'hFF, 4'hF, RESP_OKAY);
    wr(OFS_POWER_MASK, 8'h00, 4'hE, RESP_OKAY);
    wr(OFS_ALERT_MASK_HI, 8'h00, 4'hF, RESP_OKAY);
    m_amask = 8'hF8;
    check_all();
    for (int i = 0; i < 24; i++) begin
      v = xs();
      wr(OFS_ALERT_MASK_HI, v[7:0], 4'hF, RESP_OKAY);
      m_amask = {5'h1F, v[2:0]};
      wr(OFS_POWER_MASK, v[15:8], 4'hF, RESP_OKAY);
      m_pmask = v[15:8];
      v = xs();
      @(posedge aclk);
      alert_hi_evt <= v[7:0];
      power_evt <= (i % 3 == 0) ? 8'h01 : v[15:8];
      @(posedge aclk);
      m_astat = m_astat | (v[7:0] & 8'h07);
      m_pstat = m_pstat | ((i % 3 == 0) ? 8'h01 : v[15:8]);
      alert_hi_evt <= 8'h00;
      power_evt <= 8'h00;
      check_all();
      v = xs();
      wr(OFS_ALERT_STAT_HI, v[7:0], 4'hF, RESP_OKAY);
      m_astat = m_astat & ~v[7:0];
      wr(OFS_POWER_STAT, v[15:8], 4'hF, RESP_OKAY);
      m_pstat = m_pstat & ~v[15:8];
      check_all();
    end
    // Event held high across its own clear: the set must win
    power_evt <= 8'h01;
    wr(OFS_POWER_STAT, 8'h01, 4'hF, RESP_OKAY);
    power_evt <= 8'h00;
    m_pstat[0] = 1'b1;
    check_all();
    wr(OFS_CONTROL, 8'h00, 4'hF, RESP_OKAY);
    m_ctrl = 8'h00;
    wr(OFS_POWER_MASK, 8'h00, 4'hF, RESP_OKAY);
    m_pmask = 8'h00;
    hr_pulse(1'b0);
    check_all();
    wr(OFS_CONTROL, 8'h01, 4'hF, RESP_OKAY);
    m_ctrl = 8'h01;
    hr_pulse(1'b0);
    check_all();
    wr(OFS_CONTROL, 8'h00, 4'hF, RESP_OKAY);
    m_ctrl = 8'h00;
    wr(OFS_POWER_MASK, 8'h5A, 4'hF, RESP_OKAY);
    m_pmask = 8'h5A;
    hr_pulse(1'b1);
    check_all();
    wr(OFS_POWER_MASK, 8'h00, 4'hF, RESP_OKAY);
    do_reset();
    check_all();
    complete_run();
  end
endmodule // alert_event_mask_bits_tb
